/* logic/hps_pkg.sv */
// ****************************************************************
// Register map and field layout
// ****************************************************************
package hps_pkg;
	localparam logic [7:0] SLOT_CTRL_STAT_OFS = 8'hd8;
	localparam logic [7:0] DEV_CAP_TWO_OFS    = 8'he4;
	localparam logic [7:0] LINK_STAT_OFS      = 8'hd0;

	localparam int EN_BUTTON_BIT   = 0;
	localparam int EN_FAULT_BIT    = 1;
	localparam int EN_PRES_BIT     = 3;
	localparam int EN_CMD_BIT      = 4;
	localparam int EN_MASTER_BIT   = 5;
	localparam int ATTN_LSB        = 6;
	localparam int PWR_IND_LSB     = 8;
	localparam int PWR_CTRL_BIT    = 10;
	localparam int EN_DLL_BIT      = 12;
	localparam int ST_BUTTON_BIT   = 16;
	localparam int ST_FAULT_BIT    = 17;
	localparam int ST_LATCH_CH_BIT = 18;
	localparam int ST_PRES_CH_BIT  = 19;
	localparam int ST_CMD_BIT      = 20;
	localparam int ST_LATCH_BIT    = 21;
	localparam int ST_PRES_BIT     = 22;
	localparam int ST_DLL_BIT      = 24;
	localparam int LINK_ACTIVE_BIT = 29;
	localparam int LTR_CAP_BIT     = 11;
	localparam int OBFF_CAP_LSB    = 18;

	localparam logic [1:0] IND_ON    = 2'h1;
	localparam logic [1:0] IND_BLINK = 2'h2;
	localparam logic [1:0] IND_OFF   = 2'h3;

	localparam logic [12:0] CTRL_RST      = 13'h03c0;
	localparam logic [12:0] CTRL_WMASK    = 13'h17fb;
	localparam logic        DLL_CH_RST    = 1'h1;
	localparam logic [31:0] DEV_CAP_TWO   = 32'h0004_0800;
endpackage

/* logic/hps_slot.sv */
// Contract
// R1 - Button event enable gates interrupt
// R2 - Power fault enable gates interrupt
// R3 - Presence change enable gates interrupt
// R4 - Command complete enable gates interrupt
// R5 - Master enable gates all interrupts
// R6 - Attention indicator field, reset off, sends message
// R7 - Power indicator field, reset off, sends message
// R8 - Bit 10 zero powers slot on
// R9 - Link state change enable notifies software
// R10 - Button status sticky, write one clears
// R11 - Fault status sticky, write one clears
// R12 - Latch changed status read-only
// R13 - Presence change sticky, write one clears
// R14 - Command done sticky, write one clears
// R15 - Latch state read-only, zero closed
// R16 - Presence state, one card present
// R17 - No slot means presence reads one
// R18 - Presence reset follows inverted strap
// R19 - Link state change sticky, resets one
// R20 - Latency reporting capability bit reads one
// R21 - Buffer flush field reads 01b
// R22 - Link active reads state machine active
// R23 - Interrupt while enabled latched status
`timescale 1ns/10ps
module hps_slot (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	input  wire logic        button_i,
	input  wire logic        power_fault_i,
	input  wire logic        retention_latch_i,
	input  wire logic        card_present_i,
	input  wire logic        card_presence_strap_i,
	input  wire logic        slot_implemented_i,
	input  wire logic        cmd_done_i,
	input  wire logic        dl_active_state_i,
	output logic             slot_power_off_o,
	output logic      [1:0]  attn_ind_o,
	output logic      [1:0]  power_ind_o,
	output logic             attn_msg_o,
	output logic             power_msg_o,
	output logic             hp_irq_o
);
	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [5:0] meta_r;
	logic [5:0] sync_r;
	logic [5:0] prev_r;
	wire  [5:0] pins = {dl_active_state_i, cmd_done_i, card_present_i,
		retention_latch_i, power_fault_i, button_i};
	wire  [5:0] rise = sync_r & ~prev_r;
	wire  [5:0] chg  = sync_r ^ prev_r;
	logic       prime_r;

	always_ff @(posedge clk_i) begin
		meta_r <= pins;
		sync_r <= meta_r;
		prev_r <= sync_r;
	end

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic        ack_r;
	logic [12:0] ctrl_r;
	logic [4:0]  sticky_r;
	logic        latch_ch_r;
	logic        dll_ch_r;
	logic        pres_r;
	logic [31:0] rdat_r;
	logic        attn_msg_r;
	logic        pwr_msg_r;
	wire req      = wb_cyc_i & wb_stb_i & ~ack_r;
	wire hit_slot = wb_adr_i == hps_pkg::SLOT_CTRL_STAT_OFS;
	wire hit_cap  = wb_adr_i == hps_pkg::DEV_CAP_TWO_OFS;
	wire hit_link = wb_adr_i == hps_pkg::LINK_STAT_OFS;
	wire wr_slot  = req & wb_we_i & hit_slot;
	wire wr_lo    = wr_slot & wb_sel_i[0];
	wire wr_hi    = wr_slot & wb_sel_i[1];
	wire wr_st    = wr_slot & wb_sel_i[2];
	wire wr_st3   = wr_slot & wb_sel_i[3];
	wire [15:0] ctl_mask = {3'h0, {5{wr_hi}}, {8{wr_lo}}};
	wire [12:0] ctrl_nxt = (ctrl_r & ~ctl_mask[12:0])
		| (wb_dat_i[12:0] & ctl_mask[12:0] & hps_pkg::CTRL_WMASK);
	// Write-one-clear for button, fault, presence, command
	wire [4:0] w1c = {wb_dat_i[hps_pkg::ST_CMD_BIT],
		wb_dat_i[hps_pkg::ST_PRES_CH_BIT], 1'b0,
		wb_dat_i[hps_pkg::ST_FAULT_BIT],
		wb_dat_i[hps_pkg::ST_BUTTON_BIT]} & {5{wr_st}};
	wire [4:0] ev  = {rise[4], chg[3], 1'b0, rise[1], rise[0]};
	// Set wins over a clear in the same cycle
	wire [4:0] sticky_nxt = (sticky_r & ~w1c) | ev; // R10 R11 R13 R14
	wire dll_ch_nxt = (dll_ch_r & ~(wr_st3 & wb_dat_i[hps_pkg::ST_DLL_BIT]))
		| (chg[5] & prime_r); // R19
	// Presence forced to one when no slot is wired
	wire pres_rd = slot_implemented_i ? pres_r : 1'b1; // R16 R17

	wire [31:0] slot_word = {7'h0, dll_ch_r, 1'b0, pres_rd,
		latch_r_bit(sync_r[2]), sticky_r[4], sticky_r[3], latch_ch_r,
		sticky_r[1], sticky_r[0], 3'h0, ctrl_r};
	wire [31:0] link_word = {2'h0, sync_r[5], 29'h0}; // R22
	wire [31:0] rdat_nxt = hit_slot ? slot_word :
		hit_cap ? hps_pkg::DEV_CAP_TWO : // R20 R21
		hit_link ? link_word : 32'h0000_0000;

	function automatic logic latch_r_bit(input logic v);
		latch_r_bit = v; // R15
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r      <= 1'b0;
			ctrl_r     <= hps_pkg::CTRL_RST; // R6 R7 R8
			sticky_r   <= 5'h00;
			latch_ch_r <= 1'b0;
			dll_ch_r   <= hps_pkg::DLL_CH_RST; // R19
			rdat_r     <= 32'h0000_0000;
			attn_msg_r <= 1'b0;
			pwr_msg_r  <= 1'b0;
			prime_r    <= 1'b0;
		end else begin
			ack_r      <= req;
			ctrl_r     <= ctrl_nxt;
			sticky_r   <= sticky_nxt;
			// Latch change is hardware-only; software cannot clear it
			latch_ch_r <= latch_ch_r | (chg[2] & prime_r); // R12
			dll_ch_r   <= dll_ch_nxt;
			prime_r    <= 1'b1;
			if (req)
				rdat_r <= rdat_nxt;
			attn_msg_r <= wr_lo; // R6
			pwr_msg_r  <= wr_hi; // R7
		end
	end

	// Strap caught on release, not under reset
	logic rst_d_r;
	always_ff @(posedge clk_i) begin
		rst_d_r <= rst_i;
		if (rst_i)
			pres_r <= 1'b0;
		else if (rst_d_r)
			pres_r <= ~card_presence_strap_i; // R18
		else
			pres_r <= sync_r[3]; // R16
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	wire [4:0] en = {ctrl_r[hps_pkg::EN_CMD_BIT],
		ctrl_r[hps_pkg::EN_PRES_BIT], 1'b0,
		ctrl_r[hps_pkg::EN_FAULT_BIT], ctrl_r[hps_pkg::EN_BUTTON_BIT]};
	wire any_ev = |(sticky_r & en) // R1 R2 R3 R4
		| (dll_ch_r & ctrl_r[hps_pkg::EN_DLL_BIT]); // R9
	logic irq_r;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_r <= 1'b0;
		else
			irq_r <= any_ev & ctrl_r[hps_pkg::EN_MASTER_BIT]; // R5 R23
	end

	assign wb_ack_o         = ack_r;
	assign wb_dat_o         = rdat_r;
	assign hp_irq_o         = irq_r;
	assign attn_msg_o       = attn_msg_r;
	assign power_msg_o      = pwr_msg_r;
	assign attn_ind_o       = ctrl_r[hps_pkg::ATTN_LSB +: 2];
	assign power_ind_o      = ctrl_r[hps_pkg::PWR_IND_LSB +: 2];
	assign slot_power_off_o = ctrl_r[hps_pkg::PWR_CTRL_BIT]; // R8

	// ************************************************************
	// Checks
	// ************************************************************
	property p_master_gate;
		@(posedge clk_i) disable iff (rst_i)
		!ctrl_r[hps_pkg::EN_MASTER_BIT] |=> !hp_irq_o;
	endproperty
	a_master_gate: assert property (p_master_gate) // R5
		else $error("irq without master enable");

	property p_irq_cause;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_r[hps_pkg::EN_MASTER_BIT] && ctrl_r[hps_pkg::EN_BUTTON_BIT]
			&& sticky_r[0]) |=> hp_irq_o;
	endproperty
	a_irq_cause: assert property (p_irq_cause) // R1
		else $error("button event did not raise irq");

	property p_button_sticky;
		@(posedge clk_i) disable iff (rst_i)
		(sticky_r[0] && !w1c[0]) |=> sticky_r[0];
	endproperty
	a_button_sticky: assert property (p_button_sticky) // R10
		else $error("button status lost");

	property p_fault_set;
		@(posedge clk_i) disable iff (rst_i)
		rise[1] |=> sticky_r[1];
	endproperty
	a_fault_set: assert property (p_fault_set) // R11
		else $error("fault status not set");

	property p_no_slot;
		@(posedge clk_i) !slot_implemented_i |-> pres_rd;
	endproperty
	a_no_slot: assert property (p_no_slot) // R17
		else $error("presence not forced");

	property p_attn_msg;
		@(posedge clk_i) disable iff (rst_i)
		wr_lo |=> attn_msg_o ##1 !attn_msg_o;
	endproperty
	a_attn_msg: assert property (p_attn_msg) // R6
		else $error("attention message missing");

	property p_pwr_msg;
		@(posedge clk_i) disable iff (rst_i)
		wr_hi |=> power_msg_o;
	endproperty
	a_pwr_msg: assert property (p_pwr_msg) // R7
		else $error("power message missing");

	property p_latch_ro;
		@(posedge clk_i) disable iff (rst_i)
		latch_ch_r |=> latch_ch_r;
	endproperty
	a_latch_ro: assert property (p_latch_ro) // R12
		else $error("latch change cleared");

	property p_fault_irq;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_r[hps_pkg::EN_MASTER_BIT] && ctrl_r[hps_pkg::EN_FAULT_BIT]
			&& sticky_r[1]) |=> hp_irq_o;
	endproperty
	a_fault_irq: assert property (p_fault_irq) // R2
		else $error("fault event did not raise irq");

	property p_pres_irq;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_r[hps_pkg::EN_MASTER_BIT] && ctrl_r[hps_pkg::EN_PRES_BIT]
			&& sticky_r[3]) |=> hp_irq_o;
	endproperty
	a_pres_irq: assert property (p_pres_irq) // R3
		else $error("presence event did not raise irq");

	property p_cmd_irq;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_r[hps_pkg::EN_MASTER_BIT] && ctrl_r[hps_pkg::EN_CMD_BIT]
			&& sticky_r[4]) |=> hp_irq_o;
	endproperty
	a_cmd_irq: assert property (p_cmd_irq) // R4
		else $error("command event did not raise irq");

	property p_dll_irq;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_r[hps_pkg::EN_MASTER_BIT] && ctrl_r[hps_pkg::EN_DLL_BIT]
			&& dll_ch_r) |=> hp_irq_o;
	endproperty
	a_dll_irq: assert property (p_dll_irq) // R9
		else $error("link change did not raise irq");

	property p_irq_none;
		@(posedge clk_i) disable iff (rst_i)
		(!(|(sticky_r & en))
			&& !(dll_ch_r && ctrl_r[hps_pkg::EN_DLL_BIT])) |=> !hp_irq_o;
	endproperty
	a_irq_none: assert property (p_irq_none) // R23
		else $error("irq without enabled status");

	property p_attn_field;
		@(posedge clk_i) disable iff (rst_i)
		wr_lo |=> attn_ind_o == $past(wb_dat_i[hps_pkg::ATTN_LSB +: 2]);
	endproperty
	a_attn_field: assert property (p_attn_field) // R6
		else $error("attention field not written");

	property p_pwr_ind;
		@(posedge clk_i) disable iff (rst_i)
		wr_hi |=> power_ind_o == $past(wb_dat_i[hps_pkg::PWR_IND_LSB +: 2]);
	endproperty
	a_pwr_ind: assert property (p_pwr_ind) // R7
		else $error("power indicator not written");

	property p_pwr_ctrl;
		@(posedge clk_i) disable iff (rst_i)
		wr_hi |=> slot_power_off_o == $past(wb_dat_i[hps_pkg::PWR_CTRL_BIT]);
	endproperty
	a_pwr_ctrl: assert property (p_pwr_ctrl) // R8
		else $error("power control not written");

	property p_button_set;
		@(posedge clk_i) disable iff (rst_i)
		rise[0] |=> sticky_r[0];
	endproperty
	a_button_set: assert property (p_button_set) // R10
		else $error("button status not set");

	property p_fault_keep;
		@(posedge clk_i) disable iff (rst_i)
		(sticky_r[1] && !w1c[1]) |=> sticky_r[1];
	endproperty
	a_fault_keep: assert property (p_fault_keep) // R11
		else $error("fault status lost");

	property p_latch_set;
		@(posedge clk_i) disable iff (rst_i)
		(chg[2] && prime_r) |=> latch_ch_r;
	endproperty
	a_latch_set: assert property (p_latch_set) // R12
		else $error("latch change not set");

	property p_pres_set;
		@(posedge clk_i) disable iff (rst_i)
		chg[3] |=> sticky_r[3];
	endproperty
	a_pres_set: assert property (p_pres_set) // R13
		else $error("presence change not set");

	property p_cmd_set;
		@(posedge clk_i) disable iff (rst_i)
		rise[4] |=> sticky_r[4];
	endproperty
	a_cmd_set: assert property (p_cmd_set) // R14
		else $error("command status not set");

	property p_cmd_keep;
		@(posedge clk_i) disable iff (rst_i)
		(sticky_r[4] && !w1c[4]) |=> sticky_r[4];
	endproperty
	a_cmd_keep: assert property (p_cmd_keep) // R14
		else $error("command status lost");

	property p_latch_state;
		@(posedge clk_i) disable iff (rst_i)
		(req && hit_slot)
			|=> wb_dat_o[hps_pkg::ST_LATCH_BIT] == $past(sync_r[2]);
	endproperty
	a_latch_state: assert property (p_latch_state) // R15
		else $error("latch state misread");

	property p_pres_read;
		@(posedge clk_i) disable iff (rst_i)
		(req && hit_slot && slot_implemented_i)
			|=> wb_dat_o[hps_pkg::ST_PRES_BIT] == $past(pres_r);
	endproperty
	a_pres_read: assert property (p_pres_read) // R16
		else $error("presence state misread");

	property p_strap;
		@(posedge clk_i) disable iff (rst_i)
		(rst_d_r && !rst_i) |=> pres_r == !$past(card_presence_strap_i);
	endproperty
	a_strap: assert property (p_strap) // R18
		else $error("presence not loaded from strap");

	property p_dll_set;
		@(posedge clk_i) disable iff (rst_i)
		(chg[5] && prime_r) |=> dll_ch_r;
	endproperty
	a_dll_set: assert property (p_dll_set) // R19
		else $error("link change not set");

	property p_cap_read;
		@(posedge clk_i) disable iff (rst_i)
		(req && hit_cap) |=> wb_dat_o == hps_pkg::DEV_CAP_TWO;
	endproperty
	a_cap_read: assert property (p_cap_read) // R20 R21
		else $error("capability word misread");

	property p_link_read;
		@(posedge clk_i) disable iff (rst_i)
		(req && hit_link)
			|=> wb_dat_o[hps_pkg::LINK_ACTIVE_BIT] == $past(sync_r[5]);
	endproperty
	a_link_read: assert property (p_link_read) // R22
		else $error("link active misread");
endmodule

/* verification/hps_slot_hw.sv */
`timescale 1ns/10ps
// ************************************************
// Slot hardware model
// ************************************************
module hps_slot_hw (
	input  wire logic       clk_i,
	input  wire logic [5:0] ev_i,
	output logic            button_o,
	output logic            power_fault_o,
	output logic            cmd_done_o,
	output logic            card_present_o,
	output logic            dl_active_o,
	output logic            latch_o
);
	logic [2:0] cnt_r;
	logic [2:0] which_r;
	initial begin
		cnt_r = 3'h0;
		which_r = 3'h0;
		card_present_o = 1'b1;
		dl_active_o = 1'b0;
		latch_o = 1'b0;
	end
	// Pulses last 4 cycles so the synchroniser cannot miss them
	always @(posedge clk_i) begin
		if (|{ev_i[3], ev_i[1:0]}) begin
			cnt_r <= 3'h4;
			which_r <= {ev_i[3], ev_i[1:0]};
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
		card_present_o <= card_present_o ^ ev_i[2];
		dl_active_o <= dl_active_o ^ ev_i[4];
		latch_o <= latch_o ^ ev_i[5];
	end
	assign {cmd_done_o, power_fault_o, button_o} =
		(cnt_r != 3'h0) ? which_r : 3'h0;
endmodule

/* verification/hot_plug_slot_control_status_test.sv */
`timescale 1ns/10ps
module hot_plug_slot_control_status_test;
	logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, simp = 1, strap = 1;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, q, d;
	logic [3:0] sel = 4'h0;
	logic [5:0] ev = 6'h0;
	logic [15:0] ctl = 16'h03c0;
	logic bt, pf, cd, cp, dl, lt, po, am, pm, irq, ack;
	logic [1:0] ai, pi;
	logic [31:0] rd;
	int fail_count = 0, n_tests = 0, na = 0, np = 0, a0, p0, seed = 57236;
	int stb_t[5] = '{16, 17, 19, 20, 24};
	int en_t[5] = '{0, 1, 3, 4, 12};
	logic [3:0] sl_t[4] = '{4'hf, 4'h1, 4'h2, 4'h4};
	hps_slot u_dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_dat_o(rd), .wb_sel_i(sel), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .button_i(bt),
		.power_fault_i(pf), .retention_latch_i(lt), .card_present_i(cp),
		.card_presence_strap_i(strap), .slot_implemented_i(simp),
		.cmd_done_i(cd), .dl_active_state_i(dl), .slot_power_off_o(po),
		.attn_ind_o(ai), .power_ind_o(pi), .attn_msg_o(am),
		.power_msg_o(pm), .hp_irq_o(irq));
	hps_slot_hw u_hw (.clk_i(clk), .ev_i(ev), .button_o(bt),
		.power_fault_o(pf), .cmd_done_o(cd), .card_present_o(cp),
		.dl_active_o(dl), .latch_o(lt));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		na <= na + (am === 1'b1);
		np <= np + (pm === 1'b1);
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask
	// Holds the request until ack is sampled, then idles one cycle
	task automatic wb(logic w, logic [7:0] a, logic [31:0] v, logic [3:0] s);
		int n;
		n = 0;
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, v, s};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rd;
		if (n >= 50) chk("ack", 1, 0);
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic wait_n(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial begin
		wait_n(5);
		rst <= 0;
		wait_n(4);
		// ************************************************
		// Reset state, capability word, unmapped place
		// ************************************************
		chk("rst", 32'h0000_0f00, {20'h0, ai, pi, 6'h0, po, irq});
		wb(0, 8'hd8, 0, 4'hf);
		chk("d8", 32'h0140_03c0, q & 32'hfff7_ffff);
		wb(1, 8'he4, 32'hffff_ffff, 4'hf);
		wb(0, 8'he4, 0, 4'hf);
		chk("cap", 32'h0004_0800, q);
		wb(0, 8'h40, 0, 4'hf);
		chk("unmapped", 32'h0, q);
		// ************************************************
		// Control writes by lane, indicator messages
		// ************************************************
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			{a0, p0} = {na, np};
			wb(1, 8'hd8, d, sl_t[i % 4]);
			if (sl_t[i % 4][0]) ctl[7:0] = d[7:0];
			if (sl_t[i % 4][1]) ctl[15:8] = d[15:8];
			ctl = ctl & 16'h17fb;
			wait_n(3);
			wb(0, 8'hd8, 0, 4'hf);
			chk("ctl", {16'h0, ctl}, {16'h0, q[15:0]});
			chk("pins", {ctl[10:6]}, {po, pi, ai});
			chk("msgs", {sl_t[i % 4][1:0]}, {np - p0 > 0, na - a0 > 0});
		end
		// ************************************************
		// Events, enables and the interrupt gate
		// ************************************************
		for (int k = 0; k < 5; k++) begin
			wb(1, 8'hd8, 32'h011f_0000, 4'hf);
			wb(1, 8'hd8, 32'h1 << en_t[k], 4'hf);
			ev <= 6'h1 << k;
			wait_n(1);
			ev <= 6'h0;
			wait_n(8);
			wb(0, 8'hd8, 0, 4'hf);
			chk("ev", 2, {q[stb_t[k]], irq});
			wb(1, 8'hd8, (32'h1 << en_t[k]) | 32'h20, 4'hf);
			wait_n(3);
			chk("irq", 1, irq);
			wb(1, 8'hd8, (32'h1 << stb_t[k]) | (32'h1 << en_t[k]) | 32'h20, 4'hf);
			wait_n(3);
			wb(0, 8'hd8, 0, 4'hf);
			chk("clr", 0, {q[stb_t[k]], irq});
		end
		// ************************************************
		// Latch, presence forcing, link active
		// ************************************************
		ev <= 6'h20;
		wait_n(1);
		ev <= 6'h0;
		wait_n(8);
		wb(1, 8'hd8, 32'h0004_0000, 4'hf);
		wb(0, 8'hd8, 0, 4'hf);
		chk("latch", 2'b11, {q[21], q[18]});
		chk("present", 0, q[22]);
		simp <= 0;
		wait_n(2);
		wb(0, 8'hd8, 0, 4'hf);
		chk("noslot", 1, q[22]);
		wb(0, 8'hd0, 0, 4'hf);
		chk("dlact", 1, q[29]);
		wrap_up();
	end
endmodule
